//--- shared/grscc_pkg.sv
// Constants, register map and state type of the gate reload select capture counter.
// =====================================================================
// Overview of operation
// - Level-select strobe mode counts to terminal count twice, then disarms itself.
// - In level-select strobe mode the gate only picks the reload register.
// - At terminal count, gate high reloads from hold, gate low from load.
// - Frequency-shift mode repeats forever, gate level picking hold or load reload.
// - Capture mode starts on a valid gate edge, then ignores the gate level.
// - Capture mode copies the running count into hold on each valid gate edge while running, except in the terminal count cycle.
// - Capture mode halts at terminal count until the next valid gate edge.
// - Capture mode ignores gate edges completely while the counter is disarmed.
// - Gate action bit one with gating field zero selects the reload-select modes.
// - Gate action bit one with nonzero gating field selects save behaviour.
// - Gating field values six and seven make the gate edge sensitive.
// - Gate action bit zero with field one to five gates counting, sampled on source edges.
// - Count source is a prescaler tap, prior wrap, source pin or gate pin, either edge.
// - The first tap equals the oscillator input; taps are not visible outside.
// - Toggle output flips at each terminal count; the gate level, not the state, picks load or hold.
// - Repetitive modes keep reloading until the host sends a disarm command.
package grscc_pkg;

	// =================================================================
	// Register byte offsets.
	localparam logic [7:0] GRSCC_OFS_MODE = 8'h00;
	localparam logic [7:0] GRSCC_OFS_LOAD = 8'h04;
	localparam logic [7:0] GRSCC_OFS_HOLD = 8'h08;
	localparam logic [7:0] GRSCC_OFS_CMD = 8'h0c;
	localparam logic [7:0] GRSCC_OFS_STATUS = 8'h10;
	localparam logic [7:0] GRSCC_OFS_COUNT = 8'h14;

	// =================================================================
	// Field positions of the mode register.
	localparam int GRSCC_MODE_SRC_LSB = 0;
	localparam int GRSCC_MODE_FALL_BIT = 4;
	localparam int GRSCC_MODE_GSEL_LSB = 5;
	localparam int GRSCC_MODE_HWACT_BIT = 8;
	localparam int GRSCC_MODE_GCF_LSB = 9;
	localparam int GRSCC_MODE_REPEAT_BIT = 12;
	localparam int GRSCC_MODE_TOGGLE_BIT = 13;
	localparam int GRSCC_MODE_W = 14;

	// Field positions of the command register.
	localparam int GRSCC_CMD_ARM_BIT = 0;
	localparam int GRSCC_CMD_DISARM_BIT = 1;
	localparam int GRSCC_CMD_LOAD_BIT = 2;

	// =================================================================
	// Reset values.
	localparam logic [GRSCC_MODE_W-1:0] GRSCC_MODE_RST = 14'h0000;
	localparam logic [15:0] GRSCC_LOAD_RST = 16'h0000;
	localparam logic [15:0] GRSCC_HOLD_RST = 16'h0000;

	// =================================================================
	// Gating field codes and count source layout.
	localparam logic [2:0] GRSCC_GCF_NONE = 3'h0;
	localparam logic [2:0] GRSCC_GCF_EDGE_FALL = 3'h6;
	localparam int GRSCC_NUM_TAPS = 5;
	localparam int GRSCC_NUM_SRC = 16;
	localparam int GRSCC_DIV_BITS = 4;

	// Channel state.
	typedef enum logic [1:0] {
		GRSCC_IDLE = 2'b00,
		GRSCC_WAIT = 2'b01,
		GRSCC_RUN = 2'b10
	} grscc_state_t;

endpackage

//--- shared/grscc_tick_if.sv
// Carrier between the counting core and its source and gate front ends.
interface grscc_tick_if;
	// Selections made by software, and synchronised pin levels.
	logic [3:0] src_sel;
	logic src_fall;
	logic [2:0] gate_sel;
	logic [4:0] gate_sync;
	logic qual_sync;
	// Events and levels seen by the core.
	logic src_tick;
	logic gate_lvl;
	logic gate_rise;
	logic gate_fall;

	modport src (input src_sel, input src_fall, output src_tick, output gate_sync,
		output qual_sync);
	modport gate (input gate_sel, input gate_sync, input qual_sync, output gate_lvl,
		output gate_rise, output gate_fall);
	modport core (output src_sel, output src_fall, output gate_sel, input src_tick,
		input gate_lvl, input gate_rise, input gate_fall);
endinterface

//--- logic/grscc_src_sel.sv
// Pin synchronisers, prescaler and count source selection.
module grscc_src_sel import grscc_pkg::*; #(
	parameter int DIV_BITS = GRSCC_DIV_BITS
) (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Asynchronous pins.
	input wire logic osc_in,
	input wire logic prior_counter_wrap,
	input wire logic [4:0] source_pins,
	input wire logic [4:0] gate_pins,
	input wire logic gate_qualifier_input,
	// Core side.
	grscc_tick_if.src tick
);

	localparam int NPIN = 13;

	logic [NPIN-1:0] meta;
	logic [NPIN-1:0] stable;
	logic [GRSCC_NUM_TAPS-1:0] tap_lvl;
	logic [GRSCC_NUM_TAPS-1:0] tap_prev;
	logic [GRSCC_NUM_SRC-1:0] src_lvl;
	logic sel_lvl;
	logic sel_prev;

	// =================================================================
	// Two flip-flops on every pin; only the second stage is read.
	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= '0;
			stable <= '0;
		end else if (ce) begin
			meta <= {gate_qualifier_input, gate_pins, source_pins, prior_counter_wrap, osc_in};
			stable <= meta;
		end
	end

	// The first tap is the oscillator itself.
	assign tap_lvl[0] = stable[0];

	// =================================================================
	// Each further tap divides the one before it; the taps stay internal.
	generate
		for (genvar i = 1; i < GRSCC_NUM_TAPS; i++) begin : g_tap
			logic [DIV_BITS-1:0] div_cnt;
			always_ff @(posedge clk) begin
				if (rst) begin
					div_cnt <= '0;
				end else if (ce && tap_lvl[i-1] && !tap_prev[i-1]) begin
					div_cnt <= div_cnt + 1'b1;
				end
			end
			assign tap_lvl[i] = div_cnt[DIV_BITS-1];
		end
	endgenerate

	// Source vector: taps, prior wrap, source pins, gate pins.
	assign src_lvl = {stable[11:7], stable[6:2], stable[1], tap_lvl};
	assign sel_lvl = src_lvl[tick.src_sel];
	assign tick.gate_sync = stable[11:7];
	assign tick.qual_sync = stable[12];

	// A change of source selection may produce one stray edge; arm after choosing.
	assign tick.src_tick = tick.src_fall ? (sel_prev && !sel_lvl) : (!sel_prev && sel_lvl);

	// =================================================================
	// Previous levels for edge detection.
	always_ff @(posedge clk) begin
		if (rst) begin
			tap_prev <= '0;
			sel_prev <= 1'b0;
		end else if (ce) begin
			tap_prev <= tap_lvl;
			sel_prev <= sel_lvl;
		end
	end

endmodule

//--- logic/grscc_gate_sel.sv
// Gate pin selection, qualification and edge detection.
module grscc_gate_sel import grscc_pkg::*; (
	// Clock, reset and enable.
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// Core side.
	grscc_tick_if.gate tick
);

	logic gate_prev;
	logic picked;

	// =================================================================
	// Unused selection codes read as an idle low gate.
	assign picked = (tick.gate_sel < 3'd5) ? tick.gate_sync[tick.gate_sel] : 1'b0;
	assign tick.gate_lvl = picked && tick.qual_sync;
	assign tick.gate_rise = tick.gate_lvl && !gate_prev;
	assign tick.gate_fall = !tick.gate_lvl && gate_prev;

	// Previous gate level.
	always_ff @(posedge clk) begin
		if (rst) begin
			gate_prev <= 1'b0;
		end else if (ce) begin
			gate_prev <= tick.gate_lvl;
		end
	end

endmodule

//--- logic/grscc_top.sv
// One channel of the gate reload select capture counter with its APB registers.
module grscc_top import grscc_pkg::*; #(
	parameter int CNT_W = 16,
	parameter int DIV_BITS = GRSCC_DIV_BITS
) (
	// Clock, reset and enable.
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic CE,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Count sources and gates.
	input wire logic OSC_IN,
	input wire logic PRIOR_COUNTER_WRAP,
	input wire logic [4:0] SOURCE_PINS,
	input wire logic [4:0] GATE_PINS,
	input wire logic GATE_QUALIFIER_INPUT,
	// Counter outputs.
	output logic TERMINAL_COUNT,
	output logic CNT_OUT
);

	grscc_tick_if tick ();

	logic [GRSCC_MODE_W-1:0] mode;
	logic [CNT_W-1:0] load_val;
	logic [CNT_W-1:0] hold_val;
	logic [CNT_W-1:0] count;
	grscc_state_t state;
	logic second_pass;
	logic toggle;
	logic term_pulse;
	logic [31:0] rd_data;

	// =================================================================
	// Front ends.
	grscc_src_sel #(
		.DIV_BITS(DIV_BITS)
	) u_src (
		.clk(SYS_CLK),
		.rst(SRST),
		.ce(CE),
		.osc_in(OSC_IN),
		.prior_counter_wrap(PRIOR_COUNTER_WRAP),
		.source_pins(SOURCE_PINS),
		.gate_pins(GATE_PINS),
		.gate_qualifier_input(GATE_QUALIFIER_INPUT),
		.tick(tick)
	);

	grscc_gate_sel u_gate (
		.clk(SYS_CLK),
		.rst(SRST),
		.ce(CE),
		.tick(tick)
	);

	// =================================================================
	// Mode field decode.
	logic hw_gate_action_bit;
	logic [2:0] gating_control_field;
	logic repeat_mode;
	logic toggle_mode;
	assign hw_gate_action_bit = mode[GRSCC_MODE_HWACT_BIT];
	assign gating_control_field = mode[GRSCC_MODE_GCF_LSB +: 3];
	assign repeat_mode = mode[GRSCC_MODE_REPEAT_BIT];
	assign toggle_mode = mode[GRSCC_MODE_TOGGLE_BIT];
	assign tick.src_sel = mode[GRSCC_MODE_SRC_LSB +: 4];
	assign tick.src_fall = mode[GRSCC_MODE_FALL_BIT];
	assign tick.gate_sel = mode[GRSCC_MODE_GSEL_LSB +: 3];

	// Behaviour classes chosen by the gate action bit and gating field.
	logic reload_select;
	logic save_mode;
	logic edge_gating;
	logic level_gating;
	logic needs_edge;
	assign reload_select = hw_gate_action_bit && (gating_control_field == GRSCC_GCF_NONE);
	assign save_mode = hw_gate_action_bit && (gating_control_field != GRSCC_GCF_NONE);
	assign edge_gating = (gating_control_field[2:1] == 2'b11);
	assign level_gating = !hw_gate_action_bit && (gating_control_field != GRSCC_GCF_NONE)
		&& !edge_gating;
	assign needs_edge = save_mode || (!hw_gate_action_bit && edge_gating);

	// Code six triggers on the falling gate edge, every other edge code on the rising one.
	logic gate_edge;
	assign gate_edge = (gating_control_field == GRSCC_GCF_EDGE_FALL) ? tick.gate_fall
		: tick.gate_rise;

	// =================================================================
	// APB decode. The slave never inserts wait states but stalls while CE is low.
	logic wr_en;
	logic rd_setup;
	logic hit_mode;
	logic hit_load;
	logic hit_hold;
	logic hit_cmd;
	logic hit_status;
	logic hit_count;
	logic mapped;
	assign hit_mode = (PADDR == GRSCC_OFS_MODE);
	assign hit_load = (PADDR == GRSCC_OFS_LOAD);
	assign hit_hold = (PADDR == GRSCC_OFS_HOLD);
	assign hit_cmd = (PADDR == GRSCC_OFS_CMD);
	assign hit_status = (PADDR == GRSCC_OFS_STATUS);
	assign hit_count = (PADDR == GRSCC_OFS_COUNT);
	assign mapped = hit_mode || hit_load || hit_hold || hit_cmd || hit_status || hit_count;
	assign wr_en = CE && PSEL && PENABLE && PWRITE;
	assign rd_setup = PSEL && !PENABLE && !PWRITE;
	assign PREADY = CE;
	assign PSLVERR = PSEL && PENABLE && !mapped;

	// Commands are one-cycle strobes taken from the write of the command register.
	logic cmd_arm;
	logic cmd_disarm;
	logic cmd_load;
	assign cmd_arm = wr_en && hit_cmd && PWDATA[GRSCC_CMD_ARM_BIT];
	assign cmd_disarm = wr_en && hit_cmd && PWDATA[GRSCC_CMD_DISARM_BIT];
	assign cmd_load = wr_en && hit_cmd && PWDATA[GRSCC_CMD_LOAD_BIT];

	// Read multiplexer; command reads as zero, status packs state and output.
	logic [31:0] status_word;
	assign status_word = {16'h0000, 13'h0000, CNT_OUT, state == GRSCC_RUN,
		state != GRSCC_IDLE};
	assign rd_data = hit_mode ? {{(32-GRSCC_MODE_W){1'b0}}, mode}
		: hit_load ? {{(32-CNT_W){1'b0}}, load_val}
		: hit_hold ? {{(32-CNT_W){1'b0}}, hold_val}
		: hit_status ? status_word
		: hit_count ? {{(32-CNT_W){1'b0}}, count}
		: 32'h00000000;

	// =================================================================
	// Read data is captured in the setup cycle and held through the access phase.
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			PRDATA <= 32'h00000000;
		end else if (CE && rd_setup) begin
			PRDATA <= rd_data;
		end
	end

	// Mode and load registers.
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			mode <= GRSCC_MODE_RST;
			load_val <= GRSCC_LOAD_RST[CNT_W-1:0];
		end else if (wr_en) begin
			if (hit_mode) begin
				mode <= PWDATA[GRSCC_MODE_W-1:0];
			end
			if (hit_load) begin
				load_val <= PWDATA[CNT_W-1:0];
			end
		end
	end

	// =================================================================
	// Counting decisions for this cycle.
	logic count_en;
	logic at_term;
	logic [CNT_W-1:0] reload_val;
	logic capture;
	assign count_en = tick.src_tick && (state == GRSCC_RUN)
		&& (!level_gating || tick.gate_lvl);
	// A count of one or zero ends the cycle on this source edge.
	assign at_term = count_en && (count <= {{(CNT_W-1){1'b0}}, 1'b1});
	// Gate high picks hold, gate low picks load; other modes always use load.
	assign reload_val = (reload_select && tick.gate_lvl) ? hold_val : load_val;
	// Edges only save while running; disarmed or waiting edges never save.
	assign capture = save_mode && (state == GRSCC_RUN) && gate_edge && !at_term;

	// =================================================================
	// Next state. Disarm wins over arm in the same write.
	grscc_state_t next_state;
	logic next_second;
	always_comb begin
		next_state = state;
		next_second = second_pass;
		unique case (state)
			GRSCC_IDLE: begin
				// Gate edges here are ignored.
				if (cmd_arm) begin
					next_state = needs_edge ? GRSCC_WAIT : GRSCC_RUN;
					next_second = 1'b0;
				end
			end
			GRSCC_WAIT: begin
				if (gate_edge) begin
					next_state = GRSCC_RUN;
				end
			end
			GRSCC_RUN: begin
				if (at_term) begin
					if (reload_select && !repeat_mode) begin
						// Two passes, then disarm; the gate plays no part here.
						next_state = second_pass ? GRSCC_IDLE : GRSCC_RUN;
						next_second = 1'b1;
					end else if (needs_edge) begin
						next_state = GRSCC_WAIT;
					end else begin
						next_state = GRSCC_RUN;
					end
				end
			end
			default: begin
				next_state = GRSCC_IDLE;
			end
		endcase
		if (cmd_disarm) begin
			next_state = GRSCC_IDLE;
		end
	end

	// =================================================================
	// State register.
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state <= GRSCC_IDLE;
			second_pass <= 1'b0;
		end else if (CE) begin
			state <= next_state;
			second_pass <= next_second;
		end
	end

	// Counter: reload on the very edge that reaches the end, else count down.
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			count <= '0;
		end else if (CE) begin
			if (cmd_load) begin
				count <= load_val;
			end else if (at_term) begin
				count <= reload_val;
			end else if (count_en) begin
				count <= count - 1'b1;
			end
		end
	end

	// Hold register: a hardware save wins over a software write in the same cycle.
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			hold_val <= GRSCC_HOLD_RST[CNT_W-1:0];
		end else if (CE) begin
			if (capture) begin
				hold_val <= count;
			end else if (wr_en && hit_hold) begin
				hold_val <= PWDATA[CNT_W-1:0];
			end
		end
	end

	// =================================================================
	// Outputs: one-cycle pulse at the end of each pass, or a level that toggles.
	// In toggle mode each level lasts one pass, whose length is the reload value
	// picked at the previous terminal count: load, or hold when the gate selects it.
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			term_pulse <= 1'b0;
			toggle <= 1'b0;
		end else if (CE) begin
			term_pulse <= at_term;
			if (at_term) begin
				toggle <= !toggle;
			end
		end
	end

	assign TERMINAL_COUNT = term_pulse;
	assign CNT_OUT = toggle_mode ? toggle : term_pulse;

endmodule

//--- test/grscc_src_model.sv
// Count source model that drives the oscillator pin, free-running or as counted pulses.
module grscc_src_model (
	// Clock and run mode.
	input wire logic clk,
	input wire logic free,
	// Oscillator pin.
	output logic osc
);
	timeunit 1ns;
	timeprecision 1ps;
	int ph = 0;
	// The pin starts low so that the first edge seen by the channel is a rising one.
	initial begin
		osc = 1'b0;
	end
	// Free run gives one rising edge every fourth clock, so every pass has a known length.
	always @(posedge clk) begin
		if (free) begin
			ph <= ph + 1;
			osc <= ph[1];
		end
	end
	// Pulses stay low for five clocks so the synchroniser has settled before the next one.
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			osc <= 1'b1;
			repeat (2) @(posedge clk);
			osc <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
endmodule

//--- test/grscc_assertions.sv
// Port-level checks of the counter channel, bound to its top module.
module grscc_chk import grscc_pkg::*; (
	// Clock, reset and enable.
	input wire logic SYS_CLK,
	input wire logic SRST,
	input wire logic CE,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Counter outputs.
	input wire logic TERMINAL_COUNT,
	input wire logic CNT_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================================
	// Helpers
	// The toggle bit is shadowed from finished mode writes, since no port shows it.
	logic tgl;
	wire logic wr_mode = PSEL && PENABLE && PWRITE && CE && PADDR == GRSCC_OFS_MODE;
	wire logic mapped = PADDR[1:0] == 2'b00 && PADDR <= GRSCC_OFS_COUNT;
	always_ff @(posedge SYS_CLK) begin
		if (SRST)
			tgl <= 1'b0;
		else if (wr_mode)
			tgl <= PWDATA[GRSCC_MODE_TOGGLE_BIT];
	end
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	// =====================================================================
	// Sequences and properties
	sequence s_setup; PSEL && !PENABLE && !PWRITE && CE; endsequence
	sequence s_rd(logic [7:0] a); PSEL && !PENABLE && !PWRITE && CE && PADDR == a; endsequence
	sequence s_access; PSEL && PENABLE; endsequence
	property p_err; s_access |-> PSLVERR == !mapped; endproperty
	a_err: assert property (p_err) else $error("slave error does not match decode");
	property p_err_idle; !(PSEL && PENABLE) |-> !PSLVERR; endproperty
	a_err_idle: assert property (p_err_idle) else $error("slave error outside access");
	property p_rd_hold; s_setup ##1 s_access |=> $stable(PRDATA); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved after access");
	property p_cmd_zero; s_rd(GRSCC_OFS_CMD) |=> PRDATA == 32'h0; endproperty
	a_cmd_zero: assert property (p_cmd_zero) else $error("command register read not zero");
	property p_unmapped; s_setup ##0 !mapped |=> PRDATA == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_count_hi; s_rd(GRSCC_OFS_COUNT) |=> PRDATA[31:16] == 16'h0; endproperty
	a_count_hi: assert property (p_count_hi) else $error("count read wider than counter");
	property p_tc_pulse; TERMINAL_COUNT |=> !TERMINAL_COUNT; endproperty
	a_tc_pulse: assert property (p_tc_pulse) else $error("terminal count longer than a cycle");
	property p_toggle; tgl && $past(tgl) |-> $changed(CNT_OUT) == TERMINAL_COUNT; endproperty
	a_toggle: assert property (p_toggle) else $error("toggle output off terminal count");
	property p_plain; !tgl |-> CNT_OUT == TERMINAL_COUNT; endproperty
	a_plain: assert property (p_plain) else $error("output differs from terminal count");
	property p_rst;
		@(posedge SYS_CLK) disable iff (1'b0) SRST |=> !TERMINAL_COUNT && !CNT_OUT && PRDATA == 32'h0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule
bind grscc_top grscc_chk chk_u (.SYS_CLK(SYS_CLK), .SRST(SRST), .CE(CE), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .TERMINAL_COUNT(TERMINAL_COUNT), .CNT_OUT(CNT_OUT));

//--- test/grscc_tb.sv
// Self-checking bench of the counter channel with APB driver, source model and monitor.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import grscc_pkg::*;
	// =====================================================================
	// Signals
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic gate = 1'b0;
	logic free = 1'b0;
	logic ce = 1'b1;
	logic qual = 1'b1;
	logic prior = 1'b0;
	logic [4:0] spins = 5'h00;
	logic [3:0] gx = 4'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, tc, cnt_out, osc;
	int n_fail = 0;
	int n_compared = 0;
	int gap = 0;
	int have_prev = 0;
	// Set by the caller when the next transfer follows at once with the select held.
	int b2b = 0;
	int chained = 0;
	int lv, k;
	logic [32:0] rdq[$];
	int gapq[$];
	logic [7:0] ofs[6] = '{GRSCC_OFS_MODE, GRSCC_OFS_LOAD, GRSCC_OFS_HOLD, GRSCC_OFS_CMD,
		GRSCC_OFS_STATUS, GRSCC_OFS_COUNT};
	// Clock of 25 ns.
	initial begin
		forever #12.5 clk = ~clk;
	end
	// A one-bit prescaler keeps higher taps short; the tests count on the first tap.
	grscc_top #(.CNT_W(16), .DIV_BITS(1)) dut_u (.SYS_CLK(clk), .SRST(srst), .CE(ce),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .OSC_IN(osc),
		.PRIOR_COUNTER_WRAP(prior), .SOURCE_PINS(spins), .GATE_PINS({gx, gate}),
		.GATE_QUALIFIER_INPUT(qual), .TERMINAL_COUNT(tc), .CNT_OUT(cnt_out));
	grscc_src_model src_u (.clk(clk), .free(free), .osc(osc));
	// Unselected pins carry random noise, which must never reach the count.
	always @(posedge clk) begin
		{prior, spins, gx} <= 10'($urandom);
	end
	// =====================================================================
	// Compare and report tasks
	task automatic cmp_word(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmp_gap(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// =====================================================================
	// Bus and pin tasks
	// The request is held until pready is seen high, then released at that same edge.
	// A chained transfer keeps psel high and starts its setup at that very edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] exp);
		if (chained == 0)
			@(posedge clk);
		chained = b2b;
		b2b = 0;
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		if (!w)
			rdq.push_back(exp);
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		pen <= 1'b0;
		if (chained == 0)
			psel <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask
	// Gate pulses are long against the synchroniser so each edge is surely seen.
	task automatic pulse_gate();
		gate <= 1'b1;
		repeat (8) @(posedge clk);
		gate <= 1'b0;
		repeat (8) @(posedge clk);
	endtask
	task automatic wait_tc(input int n);
		int t;
		repeat (n) begin
			t = 0;
			do begin
				@(posedge clk);
				t++;
			end while (tc !== 1'b1 && t < 400);
			if (t >= 400) begin
				n_fail++;
				final_report();
			end
			@(posedge clk);
		end
	endtask
	// Monitor: read words and pass lengths are judged as they appear at the ports.
	always @(posedge clk) begin
		gap <= gap + 1;
		if (psel && pen && !pwr && pready === 1'b1 && rdq.size() > 0)
			cmp_word({pslverr, prdata}, rdq.pop_front());
		if (tc === 1'b1) begin
			if (have_prev != 0 && gapq.size() > 0)
				cmp_gap(gap, gapq.pop_front());
			have_prev <= 1;
			gap <= 1;
		end
	end
	// Watchdog well beyond the few hundred cycles the tests need.
	initial begin
		#(25 * 5000);
		n_fail++;
		final_report();
	end
	// =====================================================================
	// Main sequence
	initial begin
		void'($urandom(5028));
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		foreach (ofs[i])
			rd(ofs[i], 32'h0);
		apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
		b2b = 1;
		wr(GRSCC_OFS_LOAD, 32'hffff1234);
		b2b = 1;
		wr(8'h18, 32'h5555);
		rd(GRSCC_OFS_LOAD, 32'h1234);
		// Strobe mode armed with the gate low, which must not hold the count back.
		wr(GRSCC_OFS_MODE, 32'h0100);
		wr(GRSCC_OFS_LOAD, 32'h3);
		wr(GRSCC_OFS_HOLD, 32'h5);
		wr(GRSCC_OFS_CMD, 32'h5);
		rd(GRSCC_OFS_CMD, 32'h0);
		rd(GRSCC_OFS_STATUS, 32'h3);
		gate <= 1'b1;
		src_u.pulses(3);
		rd(GRSCC_OFS_COUNT, 32'h5);
		gate <= 1'b0;
		src_u.pulses(4);
		rd(GRSCC_OFS_COUNT, 32'h1);
		// A source pulse while the enable is low must leave the count frozen.
		ce <= 1'b0;
		src_u.pulses(1);
		ce <= 1'b1;
		rd(GRSCC_OFS_COUNT, 32'h1);
		src_u.pulses(1);
		rd(GRSCC_OFS_COUNT, 32'h3);
		rd(GRSCC_OFS_STATUS, 32'h0);
		src_u.pulses(2);
		rd(GRSCC_OFS_COUNT, 32'h3);
		// Capture mode with a random load value and capture point.
		lv = 4 + $urandom % 8;
		k = 1 + $urandom % (lv - 2);
		wr(GRSCC_OFS_MODE, 32'h0f00);
		wr(GRSCC_OFS_LOAD, 32'(lv));
		wr(GRSCC_OFS_HOLD, 32'h0);
		wr(GRSCC_OFS_CMD, 32'h4);
		pulse_gate();
		rd(GRSCC_OFS_HOLD, 32'h0);
		rd(GRSCC_OFS_STATUS, 32'h0);
		wr(GRSCC_OFS_CMD, 32'h1);
		rd(GRSCC_OFS_STATUS, 32'h1);
		// A gate pulse masked by a low qualifier is no valid edge.
		qual <= 1'b0;
		pulse_gate();
		qual <= 1'b1;
		rd(GRSCC_OFS_STATUS, 32'h1);
		pulse_gate();
		rd(GRSCC_OFS_STATUS, 32'h3);
		src_u.pulses(k);
		pulse_gate();
		rd(GRSCC_OFS_HOLD, 32'(lv - k));
		rd(GRSCC_OFS_COUNT, 32'(lv - k));
		src_u.pulses(lv - k - 1);
		rd(GRSCC_OFS_STATUS, 32'h3);
		src_u.pulses(1);
		rd(GRSCC_OFS_STATUS, 32'h1);
		src_u.pulses(2);
		rd(GRSCC_OFS_STATUS, 32'h1);
		pulse_gate();
		rd(GRSCC_OFS_STATUS, 32'h3);
		wr(GRSCC_OFS_CMD, 32'h2);
		// Edge gating on the falling gate edge: the rising edge alone must not start it.
		wr(GRSCC_OFS_MODE, 32'h0c00);
		wr(GRSCC_OFS_CMD, 32'h1);
		gate <= 1'b1;
		repeat (6) @(posedge clk);
		rd(GRSCC_OFS_STATUS, 32'h1);
		gate <= 1'b0;
		repeat (6) @(posedge clk);
		rd(GRSCC_OFS_STATUS, 32'h3);
		wr(GRSCC_OFS_CMD, 32'h2);
		// Level gating on falling source edges: a low gate holds the count.
		wr(GRSCC_OFS_MODE, 32'h0210);
		wr(GRSCC_OFS_LOAD, 32'h5);
		wr(GRSCC_OFS_CMD, 32'h5);
		src_u.pulses(2);
		rd(GRSCC_OFS_COUNT, 32'h5);
		gate <= 1'b1;
		src_u.pulses(2);
		rd(GRSCC_OFS_COUNT, 32'h3);
		gate <= 1'b0;
		wr(GRSCC_OFS_CMD, 32'h2);
		// Frequency-shift mode on a free source: five edges per pass on hold, three on load.
		wr(GRSCC_OFS_MODE, 32'h3100);
		wr(GRSCC_OFS_LOAD, 32'h3);
		wr(GRSCC_OFS_HOLD, 32'h5);
		gate <= 1'b1;
		free <= 1'b1;
		have_prev <= 0;
		gapq = '{20, 20};
		wr(GRSCC_OFS_CMD, 32'h5);
		wait_tc(3);
		gate <= 1'b0;
		have_prev <= 0;
		gapq = '{12, 12, 12};
		wait_tc(4);
		wr(GRSCC_OFS_CMD, 32'h2);
		free <= 1'b0;
		cmp_gap(gapq.size(), 0);
		final_report();
	end
endmodule
